//--- logic/ectr_map.svh
// Register map, field positions, reset values and mode codes of the event capture timer
// Operation
// - Edge select meaning depends on mode; periodic and PWM modes ignore events.
// - Timeout mode: selected edge starts, opposite stops; single-shot: selected edge starts.
// - Capture-on-event mode: selected edge captures counter and sets flag.
// - Frequency mode: selected edge captures, clears and restarts counter, sets flag.
// - Pulse-width mode: selected edge clears and restarts, opposite edge captures and flags.
// - Combined mode: first edge restarts, opposite captures, second stops and flags.
// - Events act only while the event input enable bit is one.
// - Bit zero of the interrupt enable register enables the capture interrupt.
// - Flag clears on write of one or capture read in capture modes.
// - Periodic, timeout and single-shot modes set flag when counter reaches top.
// - Capture-on-event mode sets flag on capture; capture read clears it.
// - Frequency mode sets flag on capture and restart; capture read clears it.
// - Pulse-width mode sets flag on capture edge; capture read clears it.
// - Combined mode sets flag on second edge when counter stops.
// - PWM mode sets flag when counter reaches compare high byte.
// - Read-only run bit shows one while counting, zero when stopped.
// - Without debug run bit, unit halts and ignores events during debug halt.
// - One shared read-write eight-bit staging latch serves all sixteen-bit registers.
// - Counter is a byte pair: low byte at offset, high byte at offset plus one.
// - A bus write to the counter wins over an internal counter update.
// - Count mode codes zero to seven select the eight modes.
// - Interrupt request stays high while enabled and flag set.
// - Periodic, timeout and single-shot modes use capture/compare value as top.
`ifndef ECTR_MAP_SVH
`define ECTR_MAP_SVH

// Register indexes; the byte address is four times the index
`define ECTR_IDX_CONTROL       6'h00
`define ECTR_IDX_MODE          6'h01
`define ECTR_IDX_EVENT_CTRL    6'h04
`define ECTR_IDX_IRQ_ENABLE    6'h05
`define ECTR_IDX_IRQ_FLAG      6'h06
`define ECTR_IDX_RUN_STATE     6'h07
`define ECTR_IDX_DEBUG_CTRL    6'h08
`define ECTR_IDX_STAGING       6'h09
`define ECTR_IDX_COUNT_LO      6'h0A
`define ECTR_IDX_COUNT_HI      6'h0B
`define ECTR_IDX_CMP_LO        6'h0C
`define ECTR_IDX_CMP_HI        6'h0D

// Field positions
`define ECTR_BIT_ENABLE        0
`define ECTR_BIT_CAPTURE_EVENT_INPUT_ENABLE        0
`define ECTR_BIT_EDGE          4
`define ECTR_BIT_CAPTURE_INTERRUPT_BIT          0
`define ECTR_BIT_RUN           0
`define ECTR_BIT_RUN_DURING_DEBUG_HALT        0
`define ECTR_MODE_MSB          2

// Reset values
`define ECTR_RST_BYTE          8'h00
`define ECTR_RST_WORD          16'h0000

`endif

//--- logic/ectr_pkg.sv
// Types shared by the event capture timer
package ectr_pkg;

	typedef enum logic [2:0] {
		ECTR_PERIODIC  = 3'b000,
		ECTR_TIMEOUT   = 3'b001,
		ECTR_CAPTURE_INTERRUPT_BIT_EVT  = 3'b010,
		ECTR_FREQ      = 3'b011,
		ECTR_PULSE     = 3'b100,
		ECTR_FREQ_PW   = 3'b101,
		ECTR_SINGLE    = 3'b110,
		ECTR_PWM8      = 3'b111
	} ectr_mode_e;

	typedef enum logic [1:0] {
		ECTR_FP_FIRST  = 2'b00,
		ECTR_FP_CAPTURE_INTERRUPT_BIT   = 2'b01,
		ECTR_FP_SECOND = 2'b10
	} ectr_fp_e;

endpackage

//--- logic/ectr_top.sv
// Event capture timer: event reactions, capture flag, run state, staging latch and counter over APB
`timescale 1ns/100ps
`include "ectr_map.svh"
`default_nettype none

module ectr_top #(
	parameter int CNT_W  = 16,
	parameter int ADDR_W = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              clk_en,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              event_in,
	input  wire logic              debug_halt,
	output logic                   irq,
	output logic      [2:0]        count_mode_select,
	output logic      [CNT_W-1:0]  capture_compare_value
);

	// ****************************************************************
	// Elaboration check
	// ****************************************************************
	if (CNT_W != 16) begin : g_bad_width
		$error("ectr_top serves a 16-bit counter only");
	end
	// The byte index comes from paddr[7:2], so eight address bits are the least
	if (ADDR_W < 8) begin : g_bad_addr
		$error("ectr_top needs at least 8 address bits");
	end

	// ****************************************************************
	// Registers and decode
	// ****************************************************************
	logic                    enable_reg;
	ectr_pkg::ectr_mode_e    mode_reg;
	logic                    capture_event_input_enable_reg;
	logic                    edge_reg;
	logic                    irq_en_reg;
	logic                    flag_reg;
	logic                    run_reg;
	logic                    run_during_debug_halt_reg;
	logic [7:0]              staging_reg;
	logic [CNT_W-1:0]        count_reg;
	logic [CNT_W-1:0]        cmp_reg;
	logic                    event_prev_reg;
	ectr_pkg::ectr_fp_e      fp_state_reg;
	logic [7:0]              rd_high_reg;

	logic [5:0]              idx;
	logic                    setup;
	logic                    access;
	logic                    wr;
	logic                    rd;
	logic                    mapped;
	logic                    upper_zero;

	function automatic logic idx_mapped(input logic [5:0] i);
		unique case (i)
			`ECTR_IDX_CONTROL, `ECTR_IDX_MODE, `ECTR_IDX_EVENT_CTRL, `ECTR_IDX_IRQ_ENABLE,
			`ECTR_IDX_IRQ_FLAG, `ECTR_IDX_RUN_STATE, `ECTR_IDX_DEBUG_CTRL, `ECTR_IDX_STAGING,
			`ECTR_IDX_COUNT_LO, `ECTR_IDX_COUNT_HI, `ECTR_IDX_CMP_LO, `ECTR_IDX_CMP_HI:
				idx_mapped = 1'b1;
			default:
				idx_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic wr_at(input logic [5:0] i);
		wr_at = wr && mapped && (idx == i);
	endfunction

	assign idx     = paddr[7:2];
	// Address bits above the decoded byte must be zero, or the access is refused
	assign upper_zero = (paddr >> 8) == '0;
	assign mapped  = idx_mapped(idx) && (paddr[1:0] == 2'b00) && upper_zero;
	assign setup   = psel && !penable && clk_en;
	assign access  = psel && penable && clk_en;
	assign wr      = access && pwrite;
	assign rd      = access && !pwrite && mapped;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ****************************************************************
	// Event qualification
	// ****************************************************************
	logic halted;
	logic ev_rise;
	logic ev_fall;
	logic ev_sel;
	logic ev_opp;
	logic capture_interrupt_bit_mode;

	assign halted    = debug_halt && !run_during_debug_halt_reg;
	assign ev_rise   = event_in && !event_prev_reg && capture_event_input_enable_reg && enable_reg && !halted;
	assign ev_fall   = !event_in && event_prev_reg && capture_event_input_enable_reg && enable_reg && !halted;
	assign ev_sel    = edge_reg ? ev_fall : ev_rise;
	assign ev_opp    = edge_reg ? ev_rise : ev_fall;
	assign capture_interrupt_bit_mode = (mode_reg == ectr_pkg::ECTR_CAPTURE_INTERRUPT_BIT_EVT) || (mode_reg == ectr_pkg::ECTR_FREQ) ||
	                   (mode_reg == ectr_pkg::ECTR_PULSE) || (mode_reg == ectr_pkg::ECTR_FREQ_PW);

	// ****************************************************************
	// Per-mode reactions
	// ****************************************************************
	logic do_start;
	logic do_stop;
	logic do_restart;
	logic do_capture;
	logic evt_flag;
	logic at_top;
	logic top_flag;
	logic pwm_wrap;
	logic counting;
	ectr_pkg::ectr_fp_e fp_next;

	// Capture modes never wrap on the compare value, since it then holds a captured count
	assign counting = run_reg && enable_reg && !halted;
	assign at_top   = counting && (count_reg == cmp_reg);
	// In PWM the low compare byte is the period and the high byte the flag point
	assign pwm_wrap = counting && (count_reg[7:0] == cmp_reg[7:0]);

	always_comb begin
		do_start   = 1'b0;
		do_stop    = 1'b0;
		do_restart = 1'b0;
		do_capture = 1'b0;
		evt_flag   = 1'b0;
		top_flag   = 1'b0;
		fp_next    = fp_state_reg;
		unique case (mode_reg)
			ectr_pkg::ECTR_PERIODIC: begin
				top_flag = at_top;
			end
			ectr_pkg::ECTR_TIMEOUT: begin
				do_start = ev_sel;
				do_stop  = ev_opp;
				top_flag = at_top;
			end
			ectr_pkg::ECTR_CAPTURE_INTERRUPT_BIT_EVT: begin
				do_capture = ev_sel;
				evt_flag   = ev_sel;
			end
			ectr_pkg::ECTR_FREQ: begin
				do_capture = ev_sel;
				do_restart = ev_sel;
				evt_flag   = ev_sel;
			end
			ectr_pkg::ECTR_PULSE: begin
				do_restart = ev_sel;
				do_capture = ev_opp;
				evt_flag   = ev_opp;
			end
			ectr_pkg::ECTR_FREQ_PW: begin
				unique case (fp_state_reg)
					ectr_pkg::ECTR_FP_FIRST: begin
						if (ev_sel) begin
							do_restart = 1'b1;
							fp_next    = ectr_pkg::ECTR_FP_CAPTURE_INTERRUPT_BIT;
						end
					end
					ectr_pkg::ECTR_FP_CAPTURE_INTERRUPT_BIT: begin
						if (ev_opp) begin
							do_capture = 1'b1;
							fp_next    = ectr_pkg::ECTR_FP_SECOND;
						end
					end
					ectr_pkg::ECTR_FP_SECOND: begin
						if (ev_sel) begin
							do_stop  = 1'b1;
							evt_flag = 1'b1;
							fp_next  = ectr_pkg::ECTR_FP_FIRST;
						end
					end
					default: fp_next = ectr_pkg::ECTR_FP_FIRST;
				endcase
			end
			ectr_pkg::ECTR_SINGLE: begin
				do_start = ev_sel && !run_reg;
				do_stop  = at_top;
				top_flag = at_top;
			end
			ectr_pkg::ECTR_PWM8: begin
				top_flag = counting && (count_reg[7:0] == cmp_reg[15:8]);
			end
		endcase
	end

	// ****************************************************************
	// Run state
	// ****************************************************************
	// Timeout, single-shot and combined modes follow start and stop; all other modes run whenever the unit is enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_reg <= 1'b0;
		end else if (clk_en) begin
			if (!enable_reg) begin
				run_reg <= 1'b0;
			end else if (mode_reg == ectr_pkg::ECTR_TIMEOUT || mode_reg == ectr_pkg::ECTR_SINGLE ||
			             mode_reg == ectr_pkg::ECTR_FREQ_PW) begin
				if (do_start || do_restart) begin
					run_reg <= 1'b1;
				end else if (do_stop) begin
					run_reg <= 1'b0;
				end
			end else begin
				run_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fp_state_reg <= ectr_pkg::ECTR_FP_FIRST;
		end else if (clk_en) begin
			if (mode_reg != ectr_pkg::ECTR_FREQ_PW || !enable_reg) begin
				fp_state_reg <= ectr_pkg::ECTR_FP_FIRST;
			end else begin
				fp_state_reg <= fp_next;
			end
		end
	end

	// Resets to the idle low level of the event line so no false edge follows reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_prev_reg <= 1'b0;
		end else if (clk_en) begin
			event_prev_reg <= event_in;
		end
	end

	// ****************************************************************
	// Counter
	// ****************************************************************
	// A bus write outranks restart and wrap, so software reads back what it wrote
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= `ECTR_RST_WORD;
		end else if (clk_en) begin
			if (wr_at(`ECTR_IDX_COUNT_LO)) begin
				count_reg <= {staging_reg, pwdata[7:0]};
			end else if (do_restart) begin
				count_reg <= `ECTR_RST_WORD;
			end else if (mode_reg == ectr_pkg::ECTR_PWM8 && pwm_wrap) begin
				count_reg <= `ECTR_RST_WORD;
			end else if (at_top && mode_reg != ectr_pkg::ECTR_PWM8 && !capture_interrupt_bit_mode) begin
				count_reg <= `ECTR_RST_WORD;
			end else if (counting) begin
				count_reg <= count_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_reg <= `ECTR_RST_WORD;
		end else if (clk_en) begin
			if (wr_at(`ECTR_IDX_CMP_LO)) begin
				cmp_reg <= {staging_reg, pwdata[7:0]};
			end else if (do_capture) begin
				cmp_reg <= count_reg;
			end
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_reg <= 1'b0;
			mode_reg   <= ectr_pkg::ECTR_PERIODIC;
			capture_event_input_enable_reg <= 1'b0;
			edge_reg   <= 1'b0;
			irq_en_reg <= 1'b0;
			run_during_debug_halt_reg <= 1'b0;
		end else if (clk_en) begin
			if (wr_at(`ECTR_IDX_CONTROL)) begin
				enable_reg <= pwdata[`ECTR_BIT_ENABLE];
			end
			if (wr_at(`ECTR_IDX_MODE)) begin
				mode_reg <= ectr_pkg::ectr_mode_e'(pwdata[`ECTR_MODE_MSB:0]);
			end
			if (wr_at(`ECTR_IDX_EVENT_CTRL)) begin
				capture_event_input_enable_reg <= pwdata[`ECTR_BIT_CAPTURE_EVENT_INPUT_ENABLE];
				edge_reg   <= pwdata[`ECTR_BIT_EDGE];
			end
			if (wr_at(`ECTR_IDX_IRQ_ENABLE)) begin
				irq_en_reg <= pwdata[`ECTR_BIT_CAPTURE_INTERRUPT_BIT];
			end
			if (wr_at(`ECTR_IDX_DEBUG_CTRL)) begin
				run_during_debug_halt_reg <= pwdata[`ECTR_BIT_RUN_DURING_DEBUG_HALT];
			end
		end
	end

	// Setting wins over a clear in the same cycle so no event is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_reg <= 1'b0;
		end else if (clk_en) begin
			if (evt_flag || top_flag) begin
				flag_reg <= 1'b1;
			end else if ((wr_at(`ECTR_IDX_IRQ_FLAG) && pwdata[`ECTR_BIT_CAPTURE_INTERRUPT_BIT]) ||
			             (rd && idx == `ECTR_IDX_CMP_LO && capture_interrupt_bit_mode)) begin
				flag_reg <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Staging latch and read path
	// ****************************************************************
	// One latch serves both pairs: interleaved accesses to the two pairs corrupt each other
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			staging_reg <= `ECTR_RST_BYTE;
		end else if (clk_en) begin
			if (wr && mapped && (idx == `ECTR_IDX_STAGING || idx == `ECTR_IDX_COUNT_HI ||
			                     idx == `ECTR_IDX_CMP_HI)) begin
				staging_reg <= pwdata[7:0];
			end else if (rd && (idx == `ECTR_IDX_COUNT_LO || idx == `ECTR_IDX_CMP_LO)) begin
				staging_reg <= rd_high_reg;
			end
		end
	end

	// Read data is sampled in the setup cycle; the high byte rides along for the latch copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata      <= 32'h0000_0000;
			rd_high_reg <= `ECTR_RST_BYTE;
		end else if (setup && !pwrite) begin
			prdata      <= 32'h0000_0000;
			rd_high_reg <= (idx == `ECTR_IDX_CMP_LO) ? cmp_reg[15:8] : count_reg[15:8];
			unique case (idx)
				`ECTR_IDX_CONTROL:    prdata[`ECTR_BIT_ENABLE]  <= enable_reg;
				`ECTR_IDX_MODE:       prdata[`ECTR_MODE_MSB:0]  <= mode_reg;
				`ECTR_IDX_EVENT_CTRL: begin
					prdata[`ECTR_BIT_CAPTURE_EVENT_INPUT_ENABLE] <= capture_event_input_enable_reg;
					prdata[`ECTR_BIT_EDGE]   <= edge_reg;
				end
				`ECTR_IDX_IRQ_ENABLE: prdata[`ECTR_BIT_CAPTURE_INTERRUPT_BIT]    <= irq_en_reg;
				`ECTR_IDX_IRQ_FLAG:   prdata[`ECTR_BIT_CAPTURE_INTERRUPT_BIT]    <= flag_reg;
				`ECTR_IDX_RUN_STATE:  prdata[`ECTR_BIT_RUN]     <= run_reg;
				`ECTR_IDX_DEBUG_CTRL: prdata[`ECTR_BIT_RUN_DURING_DEBUG_HALT]  <= run_during_debug_halt_reg;
				`ECTR_IDX_STAGING:    prdata[7:0]               <= staging_reg;
				`ECTR_IDX_COUNT_LO:   prdata[7:0]               <= count_reg[7:0];
				`ECTR_IDX_COUNT_HI:   prdata[7:0]               <= staging_reg;
				`ECTR_IDX_CMP_LO:     prdata[7:0]               <= cmp_reg[7:0];
				`ECTR_IDX_CMP_HI:     prdata[7:0]               <= staging_reg;
				default:              prdata                    <= 32'h0000_0000;
			endcase
			// Refused reads return zero even where the index alone would decode
			if (!mapped) begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	assign irq                   = irq_en_reg && flag_reg;
	assign count_mode_select     = mode_reg;
	assign capture_compare_value = cmp_reg;

endmodule

`default_nettype wire

//--- bench/ectr_sva.sv
// Port-level assertions for the event capture timer
`timescale 1ns/100ps
`include "ectr_map.svh"
`default_nettype none
module ectr_sva #(
	parameter int CNT_W  = 16,
	parameter int ADDR_W = 8
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              clk_en,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              event_in,
	input wire logic              debug_halt,
	input wire logic              irq,
	input wire logic [2:0]        count_mode_select,
	input wire logic [CNT_W-1:0]  capture_compare_value
);
	logic       wr, rd_cmp, wr_cmp, clr_wr, bad, live, rise, fall, sel, opp;
	logic       ctl_en, evt_en, edge_sel, dbg_run, irq_en, ev_q;
	logic [2:0] mode_in;
	logic [5:0] idx;
	assign idx = paddr[7:2];
	assign wr = psel && penable && clk_en && pwrite && paddr[1:0] == 2'b00;
	assign rd_cmp = psel && !pwrite && idx == `ECTR_IDX_CMP_LO;
	assign wr_cmp = wr && idx == `ECTR_IDX_CMP_LO;
	assign clr_wr = wr && idx inside {`ECTR_IDX_IRQ_ENABLE, `ECTR_IDX_IRQ_FLAG};
	assign bad = paddr[1:0] != 2'b00 || idx inside {6'h02, 6'h03} || idx > 6'h0D;
	assign mode_in = pwdata[2:0];
	assign rise = event_in && !ev_q;
	assign fall = !event_in && ev_q;
	assign sel = edge_sel ? fall : rise;
	assign opp = edge_sel ? rise : fall;
	assign live = clk_en && ctl_en && evt_en && (!debug_halt || dbg_run);
	// Shadows of the control bits, taken from the same bus writes the block sees
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{ctl_en, evt_en, edge_sel, dbg_run, irq_en, ev_q} <= 6'h00;
		end else begin
			ev_q <= clk_en ? event_in : ev_q;
			if (wr && idx == `ECTR_IDX_CONTROL) ctl_en <= pwdata[0];
			if (wr && idx == `ECTR_IDX_EVENT_CTRL) {edge_sel, evt_en} <= {pwdata[4], pwdata[0]};
			if (wr && idx == `ECTR_IDX_DEBUG_CTRL) dbg_run <= pwdata[0];
			if (wr && idx == `ECTR_IDX_IRQ_ENABLE) irq_en <= pwdata[0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_irq_needs_en: assert property (irq |-> irq_en)
		else $error("irq high while capture interrupt disabled");
	a_irq_holds: assert property ($fell(irq) |-> $past(clr_wr) || $past(rd_cmp) || $past(rd_cmp, 2))
		else $error("irq dropped without a clear");
	a_capture_interrupt_bit_flag: assert property (live && irq_en && (count_mode_select inside {3'h2, 3'h3} && sel
		|| count_mode_select == 3'h4 && opp) |=> irq) else $error("capture edge raised no interrupt");
	a_capture_interrupt_bit_needs_evt: assert property (count_mode_select inside {3'h2, 3'h3, 3'h4} && !wr_cmp
		&& !(live && (count_mode_select == 3'h4 ? opp : sel)) |=> $stable(capture_compare_value))
		else $error("capture without a qualified edge");
	a_no_capture_interrupt_bit_modes: assert property (count_mode_select inside {3'h0, 3'h1, 3'h6, 3'h7} && !wr_cmp
		|=> $stable(capture_compare_value)) else $error("compare value moved in a non-capture mode");
	a_mode_write: assert property (wr && idx == `ECTR_IDX_MODE |=> count_mode_select == $past(mode_in))
		else $error("mode output does not follow write");
	a_slverr_map: assert property (psel && penable |-> pslverr == bad)
		else $error("slave error does not match address map");
	a_rd_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
endmodule
bind ectr_top ectr_sva #(.CNT_W(CNT_W), .ADDR_W(ADDR_W)) u_sva (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .event_in(event_in), .debug_halt(debug_halt), .irq(irq),
	.count_mode_select(count_mode_select), .capture_compare_value(capture_compare_value)
);
`default_nettype wire

//--- bench/ectr_host.sv
// Processor bus master and event source on the far side of the timer
`timescale 1ns/100ps
`default_nettype none
module ectr_host (
	input  wire logic        pclk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	output logic             event_in
);
	initial begin
		{psel, penable, pwrite, event_in} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// Called right after a rising edge; returns one edge after release
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
		output logic err);
		{psel, penable, pwrite} <= {1'b1, 1'b0, w};
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata[7:0];
		err = pslverr;
		{psel, penable} <= 2'b00;
		// Released lines must not keep showing the old request
		paddr <= ~a;
		pwdata <= ~{24'h00_0000, d};
		@(posedge pclk);
	endtask
	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		logic [7:0] dq;
		logic       de;
		xfer(1'b1, a + 8'h04, d[15:8], dq, de);
		xfer(1'b1, a, d[7:0], dq, de);
	endtask
	// Events are held for several cycles so the edge is always seen
	task automatic ev(input logic v, input int hold);
		event_in <= v;
		repeat (hold) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

//--- bench/tb_event_capture_timer_regs.sv
// Self-checking bench for the event capture timer
`timescale 1ns/100ps
`include "ectr_map.svh"
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_event_capture_timer_regs;
	localparam logic [7:0] A_CTL = {`ECTR_IDX_CONTROL, 2'b00};
	localparam logic [7:0] A_MODE = {`ECTR_IDX_MODE, 2'b00};
	localparam logic [7:0] A_EVT = {`ECTR_IDX_EVENT_CTRL, 2'b00};
	localparam logic [7:0] A_IEN = {`ECTR_IDX_IRQ_ENABLE, 2'b00};
	localparam logic [7:0] A_FLG = {`ECTR_IDX_IRQ_FLAG, 2'b00};
	localparam logic [7:0] A_RUN = {`ECTR_IDX_RUN_STATE, 2'b00};
	localparam logic [7:0] A_DBG = {`ECTR_IDX_DEBUG_CTRL, 2'b00};
	localparam logic [7:0] A_TMP = {`ECTR_IDX_STAGING, 2'b00};
	localparam logic [7:0] A_CNT = {`ECTR_IDX_COUNT_LO, 2'b00};
	localparam logic [7:0] A_CMP = {`ECTR_IDX_CMP_LO, 2'b00};
	logic        pclk, presetn, clk_en, psel, penable, pwrite, event_in, debug_halt, pready, pslverr, irq, err;
	logic [7:0]  paddr, q, q2;
	logic [31:0] pwdata, prdata;
	logic [2:0]  mode;
	logic [15:0] ccv;
	int          n_mismatch, check_count, cyc;
	ectr_top u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.event_in(event_in), .debug_halt(debug_halt), .irq(irq), .count_mode_select(mode),
		.capture_compare_value(ccv));
	ectr_host u_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .event_in(event_in));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.xfer(1'b1, a, d, q, err);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		u_host.xfer(1'b0, a, 8'h00, q, err);
		`CHK(q, e)
	endtask
	// Stop first so the old mode cannot react while the new one is loaded
	task automatic setup(input logic [2:0] m, input logic [7:0] evc, input logic [15:0] top);
		wr(A_CTL, 8'h00);
		wr(A_MODE, {5'h00, m});
		wr(A_EVT, evc);
		u_host.wr16(A_CMP, top);
		u_host.wr16(A_CNT, 16'h0000);
		wr(A_FLG, 8'h01);
		wr(A_IEN, 8'h01);
		wr(A_CTL, 8'h01);
	endtask
	initial begin
		{presetn, clk_en, debug_halt} = 3'b010;
		{n_mismatch, check_count, cyc} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 16; i++) begin
			rd(8'(i * 4), 8'h00);
			`CHK(err, 1'(i == 2 || i == 3 || i > 13))
		end
		wr(A_RUN, 8'h01);
		rd(A_RUN, 8'h00);
		wr(A_TMP, 8'hA5);
		rd(A_TMP, 8'hA5);
		wr(A_DBG, 8'h01);
		rd(A_DBG, 8'h01);
		rd(A_DBG + 8'h01, 8'h00);
		`CHK(err, 1'b1)
		wr(8'h08, 8'hFF);
		`CHK(err, 1'b1)
		u_host.wr16(A_CNT, 16'h1234);
		rd(A_CNT, 8'h34);
		rd(A_TMP, 8'h12);
		rd(A_CNT + 8'h04, 8'h12);
		wr(A_DBG, 8'h00);
		// Counter written while it runs: the bus value must win
		setup(3'h0, 8'h11, 16'hFFFF);
		u_host.wr16(A_CNT, 16'h5600);
		u_host.xfer(1'b0, A_CNT, 8'h00, q, err);
		`CHK(1'(q < 8'h10), 1'b1)
		rd(A_CNT + 8'h04, 8'h56);
		// Clock enable low freezes the counter: three counts pass before the freeze
		u_host.xfer(1'b0, A_CNT, 8'h00, q2, err);
		clk_en <= 1'b0;
		repeat (20) @(posedge pclk);
		clk_en <= 1'b1;
		rd(A_CNT, 8'(q2 + 8'h03));
		setup(3'h0, 8'h01, 16'h0010);
		wr(A_IEN, 8'h00);
		u_host.ev(1'b1, 20);
		u_host.ev(1'b0, 20);
		rd(A_FLG, 8'h01);
		`CHK(irq, 1'b0)
		wr(A_IEN, 8'h01);
		`CHK(irq, 1'b1)
		for (int m = 2; m <= 4; m++) begin
			for (int e = 0; e < 2; e++) begin
				setup(3'(m), {3'h0, 1'(e), 4'h1}, 16'hFFFF);
				`CHK(mode, 3'(m))
				u_host.ev(1'b1, 3);
				rd(A_FLG, {7'h00, 1'((m == 4) == (e == 1))});
				u_host.ev(1'b0, 3);
				rd(A_FLG, 8'h01);
				`CHK(irq, 1'b1)
				if (e == 0) begin
					u_host.xfer(1'b0, A_CMP, 8'h00, q2, err);
					`CHK(q2, ccv[7:0])
				end else begin
					wr(A_FLG, 8'h01);
				end
				rd(A_FLG, 8'h00);
				`CHK(irq, 1'b0)
			end
		end
		setup(3'h2, 8'h00, 16'hFFFF);
		u_host.ev(1'b1, 3);
		rd(A_FLG, 8'h00);
		wr(A_EVT, 8'h01);
		debug_halt <= 1'b1;
		u_host.ev(1'b0, 3);
		u_host.ev(1'b1, 3);
		rd(A_FLG, 8'h00);
		wr(A_DBG, 8'h01);
		u_host.ev(1'b0, 3);
		u_host.ev(1'b1, 3);
		rd(A_FLG, 8'h01);
		debug_halt <= 1'b0;
		u_host.ev(1'b0, 3);
		wr(A_DBG, 8'h00);
		for (int m = 1; m <= 6; m += 5) begin
			setup(3'(m), {3'h0, 1'(m == 6), 4'h1}, 16'h0030);
			rd(A_RUN, 8'h00);
			u_host.ev(1'b1, 3);
			rd(A_RUN, {7'h00, 1'(m == 1)});
			u_host.ev(1'b0, 3);
			rd(A_RUN, {7'h00, 1'(m == 6)});
			if (m == 1) u_host.xfer(1'b0, A_CNT, 8'h00, q2, err);
			if (m == 1) rd(A_CNT, q2);
			repeat (60) @(posedge pclk);
			rd(A_FLG, {7'h00, 1'(m == 6)});
			rd(A_RUN, 8'h00);
		end
		setup(3'h5, 8'h01, 16'hFFFF);
		rd(A_RUN, 8'h00);
		u_host.ev(1'b1, 3);
		rd(A_RUN, 8'h01);
		u_host.ev(1'b0, 3);
		rd(A_FLG, 8'h00);
		u_host.ev(1'b1, 3);
		rd(A_FLG, 8'h01);
		rd(A_RUN, 8'h00);
		u_host.ev(1'b0, 3);
		setup(3'h7, 8'h01, 16'h0820);
		rd(A_FLG, 8'h00);
		u_host.ev(1'b1, 20);
		rd(A_FLG, 8'h01);
		u_host.ev(1'b0, 3);
		wrap_up();
	end
endmodule
`default_nettype wire
